// >>> inc/bpw_pkg.sv
// package for the board power-loss, fan and watchdog supervisor
// assumes one 40 MHz system clock and synchronous inputs
package bpw_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned     CLK_HZ          = 32'h0262_5A00; // 40 MHz
  localparam int unsigned     LOSS_WINDOW_S   = 32'h0000_001E; // 30 s
  localparam longint unsigned LOSS_WINDOW_CYC = longint'(LOSS_WINDOW_S) * CLK_HZ;
  localparam int unsigned     TACH_GATE_MS    = 32'h0000_03E8; // 1000 ms
  localparam longint unsigned TACH_GATE_CYC   = longint'(CLK_HZ / 32'h0000_03E8) * TACH_GATE_MS;
  localparam int unsigned     RUNTIME_TICK_S  = 32'h0000_0001;
  localparam longint unsigned RUNTIME_TICK_CYC = longint'(RUNTIME_TICK_S) * CLK_HZ;

  // ----------------------------------------------------------------
  // fan drive and speed sense
  // ----------------------------------------------------------------
  localparam int unsigned DUTY_W         = 32'h0000_0008;
  localparam int unsigned RPM_W          = 32'h0000_0010;
  localparam int unsigned PULSES_PER_REV = 32'h0000_0002;
  // gates per minute over pulses per rev: 60000 ms / (1000 ms * 2)
  localparam int unsigned RPM_SCALE      = 32'h0000_EA60 / (TACH_GATE_MS * PULSES_PER_REV);
  localparam logic [2:0]  PWM_PRESC_LAST = 3'h5; // six clocks per pwm step, about 26 kHz
  localparam logic [7:0]  DUTY_FULL      = 8'hFF;
  localparam logic [15:0] RPM_MAX        = 16'hFFFF;

  // ----------------------------------------------------------------
  // watchdog and counters
  // ----------------------------------------------------------------
  localparam int unsigned WD_STAGES = 32'h0000_0003;
  localparam int unsigned WD_TMO_W  = 32'h0000_0018;
  localparam int unsigned CNT_W     = 32'h0000_0020;
  localparam logic        LAST_STATE_RST = 1'b0;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    POL_TURN_ON    = 2'h0,
    POL_REMAIN_OFF = 2'h1,
    POL_LAST_STATE = 2'h2
  } bpw_policy_t;

  // gray order off -> on -> watch -> lost
  typedef enum logic [1:0] {
    SUP_OFF   = 2'b00,
    SUP_ON    = 2'b01,
    SUP_WATCH = 2'b11,
    SUP_LOST  = 2'b10
  } bpw_sup_t;

  typedef enum logic [1:0] {
    WD_ACT_NONE   = 2'h0,
    WD_ACT_RESET  = 2'h1,
    WD_ACT_PWRBTN = 2'h2,
    WD_ACT_NMI    = 2'h3
  } bpw_wd_act_t;

endpackage : bpw_pkg

// >>> inc/bpw_fan_if.sv
// signals between the supervisor and its fan drive block
// assumes both ends share the system clock
`timescale 1ns/1ps
`default_nettype none
interface bpw_fan_if;
  logic [7:0]  duty;
  logic        sense;
  logic        drive;
  logic [15:0] rpm;
  logic        rpm_valid;
  modport fan (input duty, input sense, output drive, output rpm, output rpm_valid);
  modport ctl (output duty, output sense, input drive, input rpm, input rpm_valid);
endinterface : bpw_fan_if
`default_nettype wire

// >>> rtl/bpw_fan_drive.sv
// fan pwm drive and tachometer speed readout
// assumes sense input synchronous to i_clk_sys, two pulses per revolution
`timescale 1ns/1ps
`default_nettype none
module bpw_fan_drive
  import bpw_pkg::*;
#(
  parameter int unsigned P_GATE_CYC = 32'(TACH_GATE_CYC)
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // fan side
  bpw_fan_if.fan   fan
);

  // ----------------------------------------------------------------
  // pwm drive
  // ----------------------------------------------------------------
  logic [2:0]  presc_q;
  logic [7:0]  pwm_cnt_q;
  logic        drive_q;

  // prescaled 8-bit ramp compared with the duty
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      presc_q   <= 3'h0;
      pwm_cnt_q <= 8'h00;
      drive_q   <= 1'b0;
    end else begin
      presc_q <= (presc_q == PWM_PRESC_LAST) ? 3'h0 : presc_q + 3'h1;
      if (presc_q == PWM_PRESC_LAST) begin
        pwm_cnt_q <= pwm_cnt_q + 8'h01;
      end
      drive_q <= (fan.duty == DUTY_FULL) || (pwm_cnt_q < fan.duty);
    end
  end
  assign fan.drive = drive_q;

  // ----------------------------------------------------------------
  // tachometer gate counter
  // ----------------------------------------------------------------
  logic        sense_prev_q;
  logic [31:0] gate_cnt_q;
  logic [15:0] pulse_cnt_q;
  logic [15:0] rpm_q;
  logic        rpm_valid_q;
  logic        rise;
  logic        gate_end;
  logic [31:0] rpm_prod;

  assign rise     = fan.sense & ~sense_prev_q;
  assign gate_end = (gate_cnt_q == P_GATE_CYC - 32'h1);
  assign rpm_prod = 32'(pulse_cnt_q) * RPM_SCALE;

  // pulses counted over a fixed gate, scaled and halved to rpm
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sense_prev_q <= 1'b0;
      gate_cnt_q   <= 32'h0000_0000;
      pulse_cnt_q  <= 16'h0000;
      rpm_q        <= 16'h0000;
      rpm_valid_q  <= 1'b0;
    end else begin
      sense_prev_q <= fan.sense;
      rpm_valid_q  <= gate_end;
      if (gate_end) begin
        gate_cnt_q  <= 32'h0000_0000;
        pulse_cnt_q <= {15'h0000, rise}; // an edge on the last cycle opens the next gate
        rpm_q       <= (rpm_prod > 32'(RPM_MAX)) ? RPM_MAX : rpm_prod[15:0];
      end else begin
        gate_cnt_q <= gate_cnt_q + 32'h1;
        if (rise && pulse_cnt_q != 16'hFFFF) begin
          pulse_cnt_q <= pulse_cnt_q + 16'h0001;
        end
      end
    end
  end
  assign fan.rpm       = rpm_q;
  assign fan.rpm_valid = rpm_valid_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  property p_rpm_scaled;
    gate_end && rpm_prod <= 32'(RPM_MAX) |=> rpm_valid_q && 32'(rpm_q) == 32'($past(pulse_cnt_q)) * RPM_SCALE;
  endproperty
  a_rpm_scaled : assert property (p_rpm_scaled) else $error("rpm not pulse count times scale");

  property p_pwm_zero;
    fan.duty == 8'h00 ##1 fan.duty == 8'h00 |-> !drive_q;
  endproperty
  a_pwm_zero : assert property (p_pwm_zero) else $error("drive high at zero duty");

  c_rpm_update : cover property (rpm_valid_q && rpm_q != 16'h0000);

endmodule : bpw_fan_drive
`default_nettype wire

// >>> rtl/bpw_board_supervisor.sv
// board supervisor: power-loss classification and restore policy,
// software watchdog, runtime and boot counters, fan drive
// assumes synchronous inputs on one 40 MHz clock and pulse commands
//
// Contract
// - after power loss or soft-off the standby rail is watched without pause.
// - standby stable for a whole 30 s window means the system was switched off properly.
// - standby lost before the 30 s window ends is classed as an ac power loss.
// - on standby restore one chosen policy applies: turn on, remain off, or last state.
// - the 30 s window runs only while the last-state policy is chosen.
// - a loss within 30 s of a regular shutdown may leave the remembered state on.
// - with a supply that has no standby rail the policy has no effect.
// - fan speed is set by a pulse-width modulated drive output.
// - the watchdog has several successive stages restarted only by software.
// - no pin lets outside hardware trigger or restart the watchdog.
// - the watchdog has no stage action that raises a non-maskable interrupt.
// - runtime and boot counters accumulate and are readable.
`timescale 1ns/1ps
`default_nettype none
module bpw_board_supervisor
  import bpw_pkg::*;
#(
  parameter int unsigned P_WINDOW_CYC = 32'(LOSS_WINDOW_CYC),
  parameter int unsigned P_TICK_CYC   = 32'(RUNTIME_TICK_CYC),
  parameter int unsigned P_GATE_CYC   = 32'(TACH_GATE_CYC)
) (
  // clock and reset
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_reset_n,
  // power supply and commands
  input  wire logic                                i_standby_ok,
  input  wire logic                                i_atx_supply,
  input  wire logic [1:0]                          i_policy,
  input  wire logic                                i_power_on_cmd,
  input  wire logic                                i_shutdown_cmd,
  output logic                                     o_system_on,
  output logic                                     o_last_state,
  output logic                                     o_evt_clean_off,
  output logic                                     o_evt_ac_loss,
  // watchdog, software side only
  input  wire logic                                i_wd_enable,
  input  wire logic                                i_wd_sw_restart,
  input  wire logic [WD_STAGES-1:0][WD_TMO_W-1:0]  i_wd_stage_tmo,
  input  wire logic [WD_STAGES-1:0][1:0]           i_wd_stage_act,
  output logic [1:0]                               o_wd_stage,
  output logic                                     o_wd_reset,
  output logic                                     o_wd_pwrbtn,
  // board information
  output logic [CNT_W-1:0]                         o_runtime_sec,
  output logic [CNT_W-1:0]                         o_boot_count,
  // fan
  input  wire logic [DUTY_W-1:0]                   i_fan_duty,
  input  wire logic                                i_fan_speed_sense,
  output logic                                     o_fan_speed_drive,
  output logic [RPM_W-1:0]                         o_fan_rpm,
  output logic                                     o_fan_rpm_valid
);

  // ----------------------------------------------------------------
  // power-loss supervisor
  // ----------------------------------------------------------------
  bpw_sup_t    sup_q, sup_d;
  logic [31:0] win_cnt_q;
  logic        last_state_q;
  logic        sys_on_q;
  logic        clean_q, loss_q;
  logic        win_done, sb_lost, restore_on, last_pol;

  assign last_pol   = (bpw_policy_t'(i_policy) == POL_LAST_STATE);
  assign win_done   = (win_cnt_q == P_WINDOW_CYC - 32'h1);
  assign sb_lost    = i_atx_supply && !i_standby_ok;
  assign restore_on = (bpw_policy_t'(i_policy) == POL_TURN_ON) || (last_pol && last_state_q);

  // next state; a supply without standby never reaches the lost state
  always_comb begin
    sup_d = sup_q;
    case (sup_q)
      SUP_OFF: begin
        if (sb_lost) sup_d = SUP_LOST;
        else if (i_power_on_cmd) sup_d = SUP_ON;
      end
      SUP_ON: begin
        if (sb_lost) sup_d = SUP_LOST;
        else if (i_shutdown_cmd) sup_d = (last_pol && i_atx_supply) ? SUP_WATCH : SUP_OFF;
      end
      SUP_WATCH: begin
        if (sb_lost) sup_d = SUP_LOST;
        else if (i_power_on_cmd) sup_d = SUP_ON;
        else if (win_done) sup_d = SUP_OFF;
      end
      SUP_LOST: begin
        if (!sb_lost) sup_d = restore_on ? SUP_ON : SUP_OFF;
      end
      default: sup_d = SUP_OFF;
    endcase
  end

  // state, on flag and event pulses
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sup_q    <= SUP_OFF;
      sys_on_q <= 1'b0;
      clean_q  <= 1'b0;
      loss_q   <= 1'b0;
    end else begin
      sup_q    <= sup_d;
      sys_on_q <= (sup_d == SUP_ON);
      loss_q   <= (sup_q inside {SUP_ON, SUP_WATCH}) && sup_d == SUP_LOST;
      clean_q  <= (sup_q inside {SUP_ON, SUP_WATCH}) && sup_d == SUP_OFF;
    end
  end

  // window counter only counts in the watch state
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || sup_q != SUP_WATCH || sup_d != SUP_WATCH) begin
      win_cnt_q <= 32'h0000_0000;
    end else begin
      win_cnt_q <= win_cnt_q + 32'h1;
    end
  end

  // remembered state stays on through the window, so an early loss restores on
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      last_state_q <= LAST_STATE_RST;
    end else if (sup_q != SUP_ON && sup_d == SUP_ON) begin
      last_state_q <= 1'b1;
    end else if (sup_q != SUP_OFF && sup_d == SUP_OFF) begin
      // a restore into off clears it too, or a later loss would wrongly restore on
      last_state_q <= 1'b0;
    end
  end

  assign o_system_on     = sys_on_q;
  assign o_last_state    = last_state_q;
  assign o_evt_clean_off = clean_q;
  assign o_evt_ac_loss   = loss_q;

  // ----------------------------------------------------------------
  // multi-stage watchdog
  // ----------------------------------------------------------------
  // only firmware drives the restart strobe; there is no hardware trigger pin
  logic [1:0]          wd_stage_q;
  logic [WD_TMO_W-1:0] wd_cnt_q;
  logic                wd_reset_q, wd_pwrbtn_q;
  logic [WD_STAGES-1:0] stage_hit;
  logic                wd_fire;
  logic [1:0]          cur_act;

  function automatic logic act_is(input logic [1:0] act, input bpw_wd_act_t kind);
    act_is = (bpw_wd_act_t'(act) == kind);
  endfunction : act_is

  // per-stage expiry; a zero timeout behaves as one cycle
  genvar gs;
  generate
    for (gs = 0; gs < WD_STAGES; gs++) begin : g_stage
      assign stage_hit[gs] = (wd_cnt_q + 24'h00_0001 >= i_wd_stage_tmo[gs]);
    end
  endgenerate

  assign wd_fire = i_wd_enable && !i_wd_sw_restart && (32'(wd_stage_q) < WD_STAGES) && stage_hit[wd_stage_q];
  assign cur_act = (32'(wd_stage_q) < WD_STAGES) ? i_wd_stage_act[wd_stage_q] : 2'h0;

  // stage and count; restart beats expiry in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n || !i_wd_enable || i_wd_sw_restart) begin
      wd_stage_q <= 2'h0;
      wd_cnt_q   <= 24'h00_0000;
    end else if (wd_fire) begin
      wd_stage_q <= wd_stage_q + 2'h1;
      wd_cnt_q   <= 24'h00_0000;
    end else if (32'(wd_stage_q) < WD_STAGES) begin
      wd_cnt_q <= wd_cnt_q + 24'h00_0001;
    end
  end

  // action pulses; an nmi code is silently dropped
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      wd_reset_q  <= 1'b0;
      wd_pwrbtn_q <= 1'b0;
    end else begin
      wd_reset_q  <= wd_fire && act_is(cur_act, WD_ACT_RESET);
      wd_pwrbtn_q <= wd_fire && act_is(cur_act, WD_ACT_PWRBTN);
    end
  end

  assign o_wd_stage  = wd_stage_q;
  assign o_wd_reset  = wd_reset_q;
  assign o_wd_pwrbtn = wd_pwrbtn_q;

  // ----------------------------------------------------------------
  // runtime and boot counters
  // ----------------------------------------------------------------
  // kept only while the supervisor logic is powered; reset clears them
  logic [31:0]      tick_q;
  logic [CNT_W-1:0] runtime_q, boot_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      tick_q    <= 32'h0000_0000;
      runtime_q <= 32'h0000_0000;
    end else if (sys_on_q) begin
      tick_q <= (tick_q == P_TICK_CYC - 32'h1) ? 32'h0000_0000 : tick_q + 32'h1;
      if (tick_q == P_TICK_CYC - 32'h1) begin
        runtime_q <= runtime_q + 32'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      boot_q <= 32'h0000_0000;
    end else if (sup_q != SUP_ON && sup_d == SUP_ON) begin
      boot_q <= boot_q + 32'h1;
    end
  end

  assign o_runtime_sec = runtime_q;
  assign o_boot_count  = boot_q;

  // ----------------------------------------------------------------
  // fan
  // ----------------------------------------------------------------
  bpw_fan_if fan_bus ();
  assign fan_bus.duty     = i_fan_duty;
  assign fan_bus.sense    = i_fan_speed_sense;
  assign o_fan_speed_drive = fan_bus.drive;
  assign o_fan_rpm        = fan_bus.rpm;
  assign o_fan_rpm_valid  = fan_bus.rpm_valid;

  bpw_fan_drive #(.P_GATE_CYC(P_GATE_CYC)) u_fan (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .fan       (fan_bus.fan)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  property p_monitor;
    (sup_q inside {SUP_OFF, SUP_ON, SUP_WATCH}) && sb_lost |=> sup_q == SUP_LOST;
  endproperty
  a_monitor : assert property (p_monitor) else $error("standby loss not caught");

  property p_clean;
    sup_q == SUP_WATCH && !sb_lost && !i_power_on_cmd && win_done |=> clean_q && sup_q == SUP_OFF && !last_state_q;
  endproperty
  a_clean : assert property (p_clean) else $error("window expiry not clean off");

  property p_loss;
    sup_q == SUP_WATCH && sb_lost |=> loss_q && !clean_q ##1 !loss_q;
  endproperty
  a_loss : assert property (p_loss) else $error("loss in window not flagged once");

  property p_restore;
    sup_q == SUP_LOST && !sb_lost |=> sys_on_q == $past(restore_on) && last_state_q == $past(restore_on);
  endproperty
  a_restore : assert property (p_restore) else $error("restore ignores policy");

  property p_watch_entry;
    sup_q == SUP_ON && sup_d == SUP_WATCH |-> last_pol ##1 win_cnt_q == 32'h0 ##1 win_cnt_q == 32'h1 || sup_q != SUP_WATCH;
  endproperty
  a_watch_entry : assert property (p_watch_entry) else $error("window without last-state policy");

  property p_keep_on;
    sup_q == SUP_WATCH |-> last_state_q;
  endproperty
  a_keep_on : assert property (p_keep_on) else $error("last state cleared early");

  property p_at_supply;
    !i_atx_supply && sup_q != SUP_LOST |=> sup_q != SUP_LOST;
  endproperty
  a_at_supply : assert property (p_at_supply) else $error("loss classed without standby rail");

  property p_wd_restart;
    i_wd_sw_restart |=> wd_stage_q == 2'h0 && wd_cnt_q == 24'h0 && !wd_reset_q && !wd_pwrbtn_q;
  endproperty
  a_wd_restart : assert property (p_wd_restart) else $error("restart did not clear watchdog");

  property p_no_nmi;
    wd_fire && act_is(cur_act, WD_ACT_NMI) |=> !wd_reset_q && !wd_pwrbtn_q && wd_stage_q == $past(wd_stage_q) + 2'h1;
  endproperty
  a_no_nmi : assert property (p_no_nmi) else $error("nmi stage acted");

  property p_boot;
    sup_q != SUP_ON && sup_d == SUP_ON |=> boot_q == $past(boot_q) + 32'h1 && last_state_q;
  endproperty
  a_boot : assert property (p_boot) else $error("boot count or last state wrong");

  c_window_clean : cover property (sup_q == SUP_WATCH ##1 clean_q);
  c_ac_loss      : cover property (loss_q ##[1:20] sys_on_q);
  c_wd_reset     : cover property (wd_reset_q);

endmodule : bpw_board_supervisor
`default_nettype wire

// >>> dv/bpw_fan_model.sv
// behavioural fan: tachometer pulses on the speed-sense line
// assumes the system clock; sense rests low while the fan is stopped
`timescale 1ns/1ps
`default_nettype none
module bpw_fan_model #(
  parameter int unsigned P_HALF_REV = 10 // clocks per half revolution
) (
  // clock and control
  input  wire logic i_clk_sys,
  input  wire logic i_run,
  // tach output
  output logic      o_sense
);
  int unsigned cnt_q;
  // -----------------------------------------------------------
  // two one-clock pulses per revolution, one each half turn
  // -----------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_run) begin
      cnt_q   <= 0;
      o_sense <= 1'b0;
    end else begin
      cnt_q   <= (cnt_q == P_HALF_REV - 1) ? 0 : cnt_q + 1;
      o_sense <= (cnt_q == 0);
    end
  end
endmodule : bpw_fan_model
`default_nettype wire

// >>> dv/bpw_board_supervisor_tb_top.sv
// self-checking bench for the board supervisor
// assumes short window, tick and gate parameters; drives at falling edge
`timescale 1ns/1ps
`default_nettype none
module bpw_board_supervisor_tb_top;
  import bpw_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic sb = 1'b1, atx = 1'b1, pon = 1'b0, sdn = 1'b0, wen = 1'b0, wrs = 1'b0, run = 1'b0;
  logic [1:0] pol = 2'h2;
  logic [WD_STAGES-1:0][WD_TMO_W-1:0] tmo = {24'h00_0002, 24'h00_0002, 24'h00_0003};
  logic [WD_STAGES-1:0][1:0] act = {2'h2, 2'h3, 2'h1};
  logic [7:0] duty = 8'h00;
  logic sense, son, lst, eco, eal, wrst, wpb, drv, rv;
  logic [1:0] wst;
  logic [31:0] rt, bc;
  logic [15:0] rpm;
  int n_mismatch = 0;
  int tests_run = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  bpw_board_supervisor #(.P_WINDOW_CYC(50), .P_TICK_CYC(10), .P_GATE_CYC(100)) uut (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_standby_ok(sb), .i_atx_supply(atx),
    .i_policy(pol), .i_power_on_cmd(pon), .i_shutdown_cmd(sdn), .o_system_on(son),
    .o_last_state(lst), .o_evt_clean_off(eco), .o_evt_ac_loss(eal), .i_wd_enable(wen),
    .i_wd_sw_restart(wrs), .i_wd_stage_tmo(tmo), .i_wd_stage_act(act), .o_wd_stage(wst),
    .o_wd_reset(wrst), .o_wd_pwrbtn(wpb), .o_runtime_sec(rt), .o_boot_count(bc),
    .i_fan_duty(duty), .i_fan_speed_sense(sense), .o_fan_speed_drive(drv),
    .o_fan_rpm(rpm), .o_fan_rpm_valid(rv));
  bpw_fan_model #(.P_HALF_REV(10)) fan (.i_clk_sys(i_clk_sys), .i_run(run), .o_sense(sense));
  // -----------------------------------------------------------
  // shared helpers
  // -----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : cyc
  function automatic logic sig(input int k);
    case (k)
      0: return eco;
      1: return eal;
      2: return wrst;
      3: return wpb;
      default: return rv;
    endcase
  endfunction : sig
  // waits for a one-cycle pulse; a used-up bound is a mismatch
  task automatic wait_sig(input int k, input int bound, input string nm);
    int i;
    for (i = 0; i < bound && sig(k) !== 1'b1; i++) cyc(1);
    chk(nm, 1, sig(k) === 1'b1);
  endtask : wait_sig
  task automatic count_sig(input int k, input int n, output int c);
    c = 0;
    repeat (n) begin
      cyc(1);
      if (sig(k) === 1'b1) c++;
    end
  endtask : count_sig
  task automatic pulse(input int which);
    if (which == 0) pon = 1'b1; else sdn = 1'b1;
    cyc(1);
    pon = 1'b0;
    sdn = 1'b0;
    cyc(1);
  endtask : pulse
  task automatic ensure_on();
    if (son !== 1'b1) pulse(0);
  endtask : ensure_on
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_clean_off();
    logic [31:0] r0;
    chk("system_on rst", 0, son);
    chk("boot rst", 0, bc);
    pulse(0);
    chk("system_on", 1, son);
    chk("last_state on", 1, lst);
    chk("boot_count", 1, bc);
    r0 = rt;
    cyc(100);
    chk("runtime delta", 1, (rt - r0) >= 9 && (rt - r0) <= 11);
    pulse(1);
    chk("system off", 0, son);
    wait_sig(0, 80, "clean_off");
    cyc(1);
    chk("last_state off", 0, lst);
    $display("test clean_off done");
  endtask : t_clean_off
  task automatic t_loss_in_window();
    pulse(0);
    pulse(1);
    cyc(10);
    sb = 1'b0;
    wait_sig(1, 3, "ac_loss");
    chk("last_state kept", 1, lst);
    cyc(2);
    sb = 1'b1;
    cyc(3);
    chk("restored on", 1, son);
    $display("test loss_in_window done");
  endtask : t_loss_in_window
  task automatic t_policies();
    int p;
    int c;
    for (p = 0; p < 2; p++) begin
      pol = p[1:0];
      ensure_on();
      sb = 1'b0;
      wait_sig(1, 3, "ac_loss pol");
      cyc(2);
      sb = 1'b1;
      cyc(3);
      chk("restore by policy", p == 0, son);
      chk("last_state by policy", p == 0, lst);
    end
    pol = 2'h0;
    ensure_on();
    pulse(1);
    cyc(2);
    chk("no window last_state", 0, lst);
    sb = 1'b0;
    count_sig(1, 5, c);
    chk("no window without last-state", 0, c);
    sb = 1'b1;
    cyc(3);
    $display("test policies done");
  endtask : t_policies
  task automatic t_at_supply();
    int c;
    atx = 1'b0;
    pol = 2'h1;
    ensure_on();
    sb = 1'b0;
    count_sig(1, 5, c);
    chk("at no loss", 0, c);
    chk("at still on", 1, son);
    sb = 1'b1;
    atx = 1'b1;
    cyc(1);
    $display("test at_supply done");
  endtask : t_at_supply
  task automatic t_watchdog();
    int c;
    wen = 1'b1;
    wait_sig(2, 10, "wd reset action");
    chk("wd stage 1", 1, wst);
    wait_sig(3, 10, "wd pwrbtn action");
    chk("wd stage all", 3, wst);
    count_sig(2, 10, c);
    chk("wd no repeat", 0, c);
    wrs = 1'b1;
    cyc(1);
    wrs = 1'b0;
    chk("wd restarted", 0, wst);
    wen = 1'b0;
    cyc(1);
    $display("test watchdog done");
  endtask : t_watchdog
  task automatic t_fan();
    int i;
    int h;
    logic [7:0] d [3] = '{8'h00, 8'h80, 8'hFF};
    for (i = 0; i < 3; i++) begin
      duty = d[i];
      cyc(3072);
      h = 0;
      repeat (1536) begin
        cyc(1);
        if (drv === 1'b1) h++;
      end
      chk("pwm high clocks", (d[i] == DUTY_FULL) ? 1536 : d[i] * 6, h);
    end
    run = 1'b1;
    wait_sig(4, 150, "rpm valid");
    cyc(1);
    wait_sig(4, 150, "rpm valid 2");
    chk("rpm", 16'h012C, rpm);
    run = 1'b0;
    $display("test fan done");
  endtask : t_fan
  initial begin
    cyc(5);
    i_reset_n = 1'b1;
    cyc(1);
    t_clean_off();
    t_loss_in_window();
    t_policies();
    t_at_supply();
    t_watchdog();
    t_fan();
    print_verdict();
  end
endmodule : bpw_board_supervisor_tb_top
`default_nettype wire
